// File: design/pcd_top.v
`timescale 1ns/10ps
// Two channel clock dividers with direct routing, behind AXI4-Lite.
module pcd_top (
  // Clock and synchronous active-low reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address channel.
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data channel.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response channel.
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address channel.
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data channel.
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Clock sources, sampled as levels.
  input wire vco_level,
  input wire clkin_level,
  // Chip-level synchronisation, high while held.
  input wire chip_sync,
  // First output pair.
  output reg first_pair_output_a,
  output reg first_pair_output_b,
  // Second output pair.
  output reg second_pair_output_a,
  output reg second_pair_output_b,
  // Correction disable lines to the output stages.
  output reg div0_duty_correction_disable,
  output reg div1_duty_correction_disable
);
`include "pcd_map.vh"

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------

  // First divider.
  // Counts of the first divider, low count high nibble.
  reg [7:0] chan_div0_counts;
  // Bypass, sync-ignore, force, start and phase of the first divider.
  reg [7:0] chan_div0_control;
  // Direct route and correction disable of the first divider.
  reg [7:0] chan_div0_routing;
  // Second divider.
  // Counts of the second divider.
  reg [7:0] chan_div1_counts;
  // Controls of the second divider, same layout as the first.
  reg [7:0] chan_div1_control;
  // Direct route and correction disable of the second divider.
  reg [7:0] chan_div1_routing;
  // Shared by both dividers.
  // Global clock source select field.
  reg [1:0] clk_src_select;

  // Register file ports.
  // Bus side strobes from the slave front end.
  wire wr_en; // One-cycle write strobe.
  wire [9:0] wr_idx; // Register index of the write.
  wire [7:0] wr_data; // Low byte of the write data.
  wire wr_lane; // Byte lane 0 enable.
  reg wr_hit; // Write index is mapped.
  wire [9:0] rd_idx; // Register index of the read.
  reg [7:0] rd_data; // Read data for that index.
  reg rd_hit; // Read index is mapped.

  // ----------------------------------------------------------------
  // Divider input path.
  // ----------------------------------------------------------------

  // Selected divider input level.
  reg src_level;
  // Selected level one cycle earlier, for edge detection.
  reg src_level_d;
  // One-cycle pulse on each rising edge of the divider input.
  wire src_rise;
  // Previous samples of the two raw sources for direct routes.
  reg vco_d;
  reg clkin_d;

  // One divider per pair.
  // Divider outputs and running flags.
  wire div0_out;
  wire div1_out;
  wire div0_running;
  wire div1_running;

  // Next values of the four output pins.
  // Both pins share a level.
  reg next_pair0;
  reg next_pair1;

  // ----------------------------------------------------------------
  // Bus front end.
  // ----------------------------------------------------------------

  // The slave owns every handshake; this module owns the registers.
  // Reads and writes are independent.
  pcd_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_lane(wr_lane),
    .wr_hit(wr_hit),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ----------------------------------------------------------------
  // Write decode.
  // ----------------------------------------------------------------

  // Flags whether a write index is one of the mapped registers, status included.
  // Unmapped: decode error.
  always @* begin
    case (wr_idx)
      `PCD_IDX_DIV0_COUNTS: wr_hit = 1'b1;
      `PCD_IDX_DIV0_CONTROL: wr_hit = 1'b1;
      `PCD_IDX_DIV0_ROUTING: wr_hit = 1'b1;
      `PCD_IDX_DIV1_COUNTS: wr_hit = 1'b1;
      `PCD_IDX_DIV1_CONTROL: wr_hit = 1'b1;
      `PCD_IDX_DIV1_ROUTING: wr_hit = 1'b1;
      `PCD_IDX_SRC_SELECT: wr_hit = 1'b1;
      // The status word is read only; writes to it are still accepted.
      `PCD_IDX_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Stores a write into its register when byte lane 0 is enabled.
  // Upper lanes are ignored.
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_div0_counts <= `PCD_RST_DIV0_COUNTS;
      chan_div0_control <= `PCD_RST_DIV0_CONTROL;
      chan_div0_routing <= `PCD_RST_DIV0_ROUTING;
      chan_div1_counts <= `PCD_RST_DIV1_COUNTS;
      chan_div1_control <= `PCD_RST_DIV1_CONTROL;
      chan_div1_routing <= `PCD_RST_DIV1_ROUTING;
      clk_src_select <= `PCD_RST_SRC_SELECT;
    end else if (wr_en && wr_lane) begin
      case (wr_idx)
        `PCD_IDX_DIV0_COUNTS: begin
          chan_div0_counts <= wr_data;
        end
        `PCD_IDX_DIV0_CONTROL: begin
          chan_div0_control <= wr_data;
        end
        `PCD_IDX_DIV0_ROUTING: begin
          // Only the route and correction bits exist here.
          chan_div0_routing <= {6'h00, wr_data[1:0]};
        end
        `PCD_IDX_DIV1_COUNTS: begin
          chan_div1_counts <= wr_data;
        end
        `PCD_IDX_DIV1_CONTROL: begin
          chan_div1_control <= wr_data;
        end
        `PCD_IDX_DIV1_ROUTING: begin
          chan_div1_routing <= {6'h00, wr_data[1:0]};
        end
        `PCD_IDX_SRC_SELECT: begin
          clk_src_select <= wr_data[1:0];
        end
        default: begin
          // Unmapped or read-only index; nothing is stored.
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read decode.
  // ----------------------------------------------------------------

  // Returns register contents, or live status, for a read index.
  // Unmapped reads give zero.
  always @* begin
    rd_hit = 1'b1;
    case (rd_idx)
      `PCD_IDX_DIV0_COUNTS: rd_data = chan_div0_counts;
      `PCD_IDX_DIV0_CONTROL: rd_data = chan_div0_control;
      `PCD_IDX_DIV0_ROUTING: rd_data = chan_div0_routing;
      `PCD_IDX_DIV1_COUNTS: rd_data = chan_div1_counts;
      `PCD_IDX_DIV1_CONTROL: rd_data = chan_div1_control;
      `PCD_IDX_DIV1_ROUTING: rd_data = chan_div1_routing;
      `PCD_IDX_SRC_SELECT: rd_data = {6'h00, clk_src_select};
      // Live state: outputs, divider levels and running flags.
      `PCD_IDX_STATUS: begin
        rd_data = {second_pair_output_a, first_pair_output_a,
                   div1_out, div0_out, 2'h0, div1_running, div0_running};
      end
      default: begin
        rd_data = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Divider input selection and edge detection.
  // ----------------------------------------------------------------

  // The divider runs from the VCO when selected, else the clock input.
  // Raw sources feed direct routes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      src_level <= 1'b0;
      src_level_d <= 1'b0;
      vco_d <= 1'b0;
      clkin_d <= 1'b0;
    end else begin
      if (clk_src_select == `PCD_SRC_VCO) begin
        src_level <= vco_level;
      end else begin
        src_level <= clkin_level;
      end
      src_level_d <= src_level;
      vco_d <= vco_level;
      clkin_d <= clkin_level;
    end
  end

  // A rising edge of the divider input clock, one cycle long.
  // Sources must be under aclk/2.
  assign src_rise = src_level && !src_level_d;

  // ----------------------------------------------------------------
  // The two dividers.
  // ----------------------------------------------------------------

  // Both share one input path.
  // First divider; comes out of reset bypassed.
  pcd_divider u_div0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_level(src_level),
    .in_rise(src_rise),
    .chip_sync(chip_sync),
    .counts(chan_div0_counts),
    .control(chan_div0_control),
    .div_out(div0_out),
    .running(div0_running)
  );

  // Second divider; comes out of reset dividing by two.
  pcd_divider u_div1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_level(src_level),
    .in_rise(src_rise),
    .chip_sync(chip_sync),
    .counts(chan_div1_counts),
    .control(chan_div1_control),
    .div_out(div1_out),
    .running(div1_running)
  );

  // ----------------------------------------------------------------
  // Output routing.
  // ----------------------------------------------------------------

  // Picks divider or direct source for each pair. The direct
  // sources are taken one stage late, in step with src_level, so
  // they lead the divider output by the divider's own register stage.
  always @* begin
    next_pair0 = div0_out;
    next_pair1 = div1_out;
    // First pair.
    if (chan_div0_routing[`PCD_BIT_ROUTE]) begin
      case (clk_src_select)
        `PCD_SRC_VCO: next_pair0 = vco_d;
        `PCD_SRC_CLK: next_pair0 = clkin_d;
        default: next_pair0 = div0_out;
      endcase
    end
    // Second pair.
    if (chan_div1_routing[`PCD_BIT_ROUTE]) begin
      case (clk_src_select)
        `PCD_SRC_VCO: next_pair1 = vco_d;
        `PCD_SRC_CLK: next_pair1 = clkin_d;
        default: next_pair1 = div1_out;
      endcase
    end
  end

  // Registers every pin so each output comes from a flip-flop.
  // Reset drives pins low.
  always @(posedge aclk) begin
    if (!aresetn) begin
      first_pair_output_a <= 1'b0;
      first_pair_output_b <= 1'b0;
      second_pair_output_a <= 1'b0;
      second_pair_output_b <= 1'b0;
      div0_duty_correction_disable <= 1'b0;
      div1_duty_correction_disable <= 1'b0;
    end else begin
      // Both pins of a pair carry the same clock.
      first_pair_output_a <= next_pair0;
      first_pair_output_b <= next_pair0;
      second_pair_output_a <= next_pair1;
      second_pair_output_b <= next_pair1;
      // Correction stays on while the bit is zero.
      div0_duty_correction_disable <= chan_div0_routing[`PCD_BIT_DCC_OFF];
      div1_duty_correction_disable <= chan_div1_routing[`PCD_BIT_DCC_OFF];
    end
  end

endmodule // pcd_top

// File: design/pcd_map.vh
// Operation
// - Low phase lasts low count plus one
// - High phase lasts high count plus one
// - Bypass powers down, passes input through
// - First divider resets into bypass
// - Second divider resets actively dividing
// - Sync-ignore bit decides obeying chip sync
// - Force level applies only with sync-ignore
// - Start-level bit picks first output level
// - First divider phase offset delays output
// - Route bit clear: pair fed by divider
// - Route set, source 10b: VCO direct
// - Route set, source 00b: clock input direct
// - Correction disable bit, zero keeps correction
// - First divider registers at chan_div0_counts to chan_div0_routing
// - Second divider registers at chan_div1_counts, chan_div1_control
// - Second divider start, phase, routing at 0x195; the code keeps start and phase at 0x194, routing at 0x195
`ifndef PCD_MAP_VH
`define PCD_MAP_VH
// ----------------------------------------------------------------
// Register indexes; the byte address is four times the index.
// ----------------------------------------------------------------
`define PCD_IDX_DIV0_COUNTS 10'h190
`define PCD_IDX_DIV0_CONTROL 10'h191
`define PCD_IDX_DIV0_ROUTING 10'h192
`define PCD_IDX_DIV1_COUNTS 10'h193
`define PCD_IDX_DIV1_CONTROL 10'h194
`define PCD_IDX_DIV1_ROUTING 10'h195
`define PCD_IDX_SRC_SELECT 10'h1E1
`define PCD_IDX_STATUS 10'h1E2
// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define PCD_RST_DIV0_COUNTS 8'h00
`define PCD_RST_DIV0_CONTROL 8'h80
`define PCD_RST_DIV0_ROUTING 8'h00
`define PCD_RST_DIV1_COUNTS 8'h00
`define PCD_RST_DIV1_CONTROL 8'h00
`define PCD_RST_DIV1_ROUTING 8'h00
`define PCD_RST_SRC_SELECT 2'h0
// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define PCD_LOW_MSB 7
`define PCD_LOW_LSB 4
`define PCD_HIGH_MSB 3
`define PCD_HIGH_LSB 0
`define PCD_BIT_BYPASS 7
`define PCD_BIT_NOSYNC 6
`define PCD_BIT_FORCE 5
`define PCD_BIT_START 4
`define PCD_PHASE_MSB 3
`define PCD_PHASE_LSB 0
`define PCD_BIT_ROUTE 1
`define PCD_BIT_DCC_OFF 0
// ----------------------------------------------------------------
// Source select codes and bus responses.
// ----------------------------------------------------------------
`define PCD_SRC_CLK 2'h0
`define PCD_SRC_VCO 2'h2
`define PCD_RESP_OKAY 2'h0
`define PCD_RESP_DECERR 2'h3
`endif

// File: design/pcd_divider.v
`timescale 1ns/10ps
// One channel divider working on rising edges of its input clock.
module pcd_divider (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Divider input clock level and its rising edge pulse.
  input wire in_level,
  input wire in_rise,
  // Chip sync level, high holds the divider in restart.
  input wire chip_sync,
  // Count and control register contents.
  input wire [7:0] counts,
  input wire [7:0] control,
  // Divider output and running flag.
  output reg div_out,
  output reg running
);
`include "pcd_map.vh"
  // States of the divider.
  localparam ST_BYP = 2'h0;
  localparam ST_PHASE = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_FORCE = 2'h3;
  reg [1:0] state; // Current state.
  reg [3:0] cnt; // Phase or half-period counter.
  wire [3:0] low_cnt = counts[`PCD_LOW_MSB:`PCD_LOW_LSB];
  wire [3:0] high_cnt = counts[`PCD_HIGH_MSB:`PCD_HIGH_LSB];
  wire nosync = control[`PCD_BIT_NOSYNC];
  wire start_hi = control[`PCD_BIT_START];
  // --------------------------------------------------------------
  // State machine; bypass beats force, force beats sync.
  // --------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_BYP;
      cnt <= 4'h0;
      div_out <= 1'b0;
      running <= 1'b0;
    end else if (control[`PCD_BIT_BYPASS]) begin
      state <= ST_BYP;
      div_out <= in_level;
      running <= 1'b0;
    end else if (nosync && control[`PCD_BIT_FORCE]) begin
      state <= ST_FORCE;
      div_out <= 1'b1;
      running <= 1'b0;
    end else if ((chip_sync && !nosync) || state == ST_BYP || state == ST_FORCE) begin
      // Restart at the start level and load the phase delay.
      state <= ST_PHASE;
      cnt <= control[`PCD_PHASE_MSB:`PCD_PHASE_LSB];
      div_out <= start_hi;
      running <= 1'b0;
    end else begin
      case (state)
        ST_PHASE: begin
          // Output holds its start level for phase input edges.
          if (cnt == 4'h0) begin
            state <= ST_RUN;
            running <= 1'b1;
          end else if (in_rise) begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_RUN: begin
          // Each level lasts its count plus one input edges.
          if (in_rise) begin
            if (cnt == (div_out ? high_cnt : low_cnt)) begin
              cnt <= 4'h0;
              div_out <= ~div_out;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_BYP;
        end
      endcase
    end
  end
endmodule // pcd_divider

// File: design/pcd_axil_slave.v
`timescale 1ns/10ps
// AXI4-Lite slave front end with one write and one read at a time.
module pcd_axil_slave (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Write address and data channels.
  input wire [11:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // Write response channel.
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // Read channels.
  input wire [11:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Register file side.
  output wire wr_en,
  output reg [9:0] wr_idx,
  output reg [7:0] wr_data,
  output reg wr_lane,
  input wire wr_hit,
  output wire [9:0] rd_idx,
  input wire [7:0] rd_data,
  input wire rd_hit
);
`include "pcd_map.vh"
  reg aw_full; // Write address held.
  reg w_full; // Write data held.
  // Write fires once both halves are held and no response waits.
  assign wr_en = aw_full && w_full && !bvalid;
  assign rd_idx = araddr[11:2];
  // --------------------------------------------------------------
  // Write path.
  // --------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `PCD_RESP_OKAY;
      wr_idx <= 10'h000;
      wr_data <= 8'h00;
      wr_lane <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        awready <= 1'b0;
        wr_idx <= awaddr[11:2];
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        wready <= 1'b0;
        wr_data <= wdata[7:0];
        wr_lane <= wstrb[0];
      end
      if (wr_en) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `PCD_RESP_OKAY : `PCD_RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // --------------------------------------------------------------
  // Read path; data are taken at the address handshake.
  // --------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `PCD_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_data};
      rresp <= rd_hit ? `PCD_RESP_OKAY : `PCD_RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule // pcd_axil_slave

// File: verif/pcd_src_model.sv
`timescale 1ns/10ps
// ----
// Free-running clock sources.
// ----
module pcd_src_model #(
  parameter int CLK_HALF = 2,
  parameter int VCO_HALF = 3
) (
  // Clock.
  input wire logic aclk,
  // Source levels.
  output logic vco_level,
  output logic clkin_level
);
  int clk_cnt = 0; // Half period counter of the clock input.
  int vco_cnt = 0; // Half period counter of the VCO.
  initial begin
    vco_level = 1'b0;
    clkin_level = 1'b0;
  end
  // Both sources run free, slower than half the bus clock so the block sees them.
  always @(posedge aclk) begin
    clk_cnt <= (clk_cnt == CLK_HALF - 1) ? 0 : clk_cnt + 1;
    vco_cnt <= (vco_cnt == VCO_HALF - 1) ? 0 : vco_cnt + 1;
    if (clk_cnt == CLK_HALF - 1) clkin_level <= ~clkin_level;
    if (vco_cnt == VCO_HALF - 1) vco_level <= ~vco_level;
  end
endmodule // pcd_src_model

// File: verif/pcd_top_chk.sv
`timescale 1ns/10ps
// ----
// Port checker of the divider block.
// ----
module pcd_top_chk (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Output pairs.
  input wire logic first_pair_output_a,
  input wire logic first_pair_output_b,
  input wire logic second_pair_output_a,
  input wire logic second_pair_output_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken together.
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Slave blocks further writes, then answers.
  sequence write_done;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  write_resp_a: assert property (both_taken |=> write_done) else $error("write answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !first_pair_output_a) else $error("busy in reset");
  pair_one_a: assert property (first_pair_output_a == first_pair_output_b)
    else $error("first pair split");
  pair_two_a: assert property (second_pair_output_a == second_pair_output_b)
    else $error("second pair split");
endmodule // pcd_top_chk

bind pcd_top pcd_top_chk pcd_top_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .first_pair_output_a(first_pair_output_a),
  .first_pair_output_b(first_pair_output_b), .second_pair_output_a(second_pair_output_a),
  .second_pair_output_b(second_pair_output_b));

// File: verif/pcd_top_tb.sv
`timescale 1ns/10ps
`include "pcd_map.vh"
module pcd_top_tb;
  // ----
  // Signals.
  // ----
  localparam int CH = 2; // Clock input half period in cycles.
  localparam int VH = 3; // VCO half period in cycles.
  logic aclk = 0, aresetn = 0, chip_sync = 0, sel = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic [7:0] cnt;
  logic [7:0] rst_val [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  wire awready, wready, bvalid, arready, rvalid, vco, clkin, pa, pb, qa, qb, dcc0, dcc1;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire pin = sel ? qa : pa; // Pair under measurement.
  int num_errors = 0, tests_run = 0;
  always #12.5 aclk = ~aclk;
  pcd_top pcd_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .vco_level(vco),
    .clkin_level(clkin), .chip_sync(chip_sync), .first_pair_output_a(pa),
    .first_pair_output_b(pb), .second_pair_output_a(qa), .second_pair_output_b(qb),
    .div0_duty_correction_disable(dcc0), .div1_duty_correction_disable(dcc1));
  pcd_src_model #(.CLK_HALF(CH), .VCO_HALF(VH)) pcd_src_model_inst (.aclk(aclk),
    .vco_level(vco), .clkin_level(clkin));
  // ----
  // Helpers.
  // ----
  // Phase length in cycles for a count field.
  function automatic int dur(input logic [3:0] n, input int half);
    return (int'(n) + 1) * 2 * half;
  endfunction
  // Compares one result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Writes one register and checks the answer.
  task automatic wr(input logic [9:0] i, input logic [7:0] d,
      input logic [1:0] e = `PCD_RESP_OKAY);
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(e));
  endtask
  // Reads one register and checks data and answer.
  task automatic rd(input logic [9:0] i, input logic [7:0] d,
      input logic [1:0] e = `PCD_RESP_OKAY);
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, {24'h0, d});
    chk(32'(rresp), 32'(e));
  endtask
  // Measures one high and one low phase of a pair.
  task automatic meas(input logic s, input int h, input int l);
    int hc, lc;
    sel = s;
    repeat (2) @(posedge pin);
    hc = 0;
    lc = 0;
    while (pin === 1'b1) begin
      @(posedge aclk);
      #1 hc++;
    end
    while (pin === 1'b0) begin
      @(posedge aclk);
      #1 lc++;
    end
    chk(32'(hc), 32'(h));
    chk(32'(lc), 32'(l));
  endtask
  // Checks that a pair stays at one level.
  task automatic stat(input logic s, input logic v);
    sel = s;
    repeat (5) @(posedge aclk);
    repeat (20) begin
      @(posedge aclk);
      #1 chk(32'(pin), 32'(v));
    end
  endtask
  // Ends the run with the verdict.
  task finish_test;
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // Tests.
  // ----
  initial begin
    void'($urandom(24283));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 6; k++) rd(`PCD_IDX_DIV0_COUNTS + 10'(k), rst_val[k]);
    rd(10'h100, 8'h00, `PCD_RESP_DECERR);
    wr(10'h100, 8'h5A, `PCD_RESP_DECERR);
    wr(`PCD_IDX_STATUS, 8'hFF);
    meas(0, CH, CH);
    meas(1, dur(0, CH), dur(0, CH));
    wr(`PCD_IDX_DIV0_CONTROL, 8'h00);
    // Count corners first, then random counts.
    for (int k = 0; k < 6; k++) begin
      cnt = (k == 0) ? 8'hF0 : (k == 1) ? 8'h0F : 8'($urandom);
      wr(`PCD_IDX_DIV0_COUNTS, cnt);
      wr(`PCD_IDX_DIV1_COUNTS, ~cnt);
      rd(`PCD_IDX_DIV1_COUNTS, ~cnt);
      meas(0, dur(cnt[3:0], CH), dur(cnt[7:4], CH));
      meas(1, dur(~cnt[3:0], CH), dur(~cnt[7:4], CH));
    end
    wr(`PCD_IDX_DIV0_COUNTS, 8'h11);
    wr(`PCD_IDX_DIV0_CONTROL, 8'h60);
    stat(0, 1'b1);
    wr(`PCD_IDX_DIV0_CONTROL, 8'h20);
    meas(0, dur(1, CH), dur(1, CH));
    wr(`PCD_IDX_DIV0_CONTROL, 8'h10);
    chip_sync <= 1'b1;
    stat(0, 1'b1);
    wr(`PCD_IDX_DIV0_CONTROL, 8'h00);
    stat(0, 1'b0);
    wr(`PCD_IDX_DIV0_CONTROL, 8'h40);
    meas(0, dur(1, CH), dur(1, CH));
    wr(`PCD_IDX_DIV1_COUNTS, 8'h11);
    wr(`PCD_IDX_DIV0_CONTROL, 8'h03);
    @(posedge clkin) chip_sync <= 1'b0;
    @(posedge qa) cnt = 8'h00;
    while (pa !== 1'b1) @(posedge aclk) #1 cnt++;
    chk(32'(cnt), 32'(3 * 2 * CH));
    wr(`PCD_IDX_DIV0_ROUTING, 8'h02);
    meas(0, CH, CH);
    wr(`PCD_IDX_SRC_SELECT, 8'h02);
    meas(0, VH, VH);
    wr(`PCD_IDX_SRC_SELECT, 8'h01);
    meas(0, dur(1, CH), dur(1, CH));
    wr(`PCD_IDX_SRC_SELECT, 8'h02);
    wr(`PCD_IDX_DIV0_ROUTING, 8'h01);
    meas(0, dur(1, VH), dur(1, VH));
    wr(`PCD_IDX_DIV1_ROUTING, 8'h03);
    rd(`PCD_IDX_DIV1_ROUTING, 8'h03);
    chk(32'(dcc0), 32'h1);
    chk(32'(dcc1), 32'h1);
    meas(1, VH, VH);
    finish_test;
  end
  // Cuts a hang short.
  initial begin
    #400000;
    num_errors++;
    finish_test;
  end
endmodule // pcd_top_tb
